// File: rtl/tic_top.sv
// Timer input capture and flag block with a Wishbone register slave.
// Assumes one 100 MHz clock, stop_i from same-clock power control.
// Contract
// [R01] Comparator path when select is one
// [R02] Comparator enabled forces port bit input
// [R03] Software sets port bit input beforehand
// [R04] Active edge copies counter into capture
// [R05] Capture bytes read-only, kept over reset
// [R06] Captured value is counter plus one
// [R07] Counter advances every four clocks
// [R08] High byte read blocks captures until low
// [R09] Status then low read clears capture flag
// [R10] Reset clears control except edge polarity
// [R11] Capture enable gates capture interrupt
// [R12] Overflow enable gates overflow interrupt
// [R13] Polarity one rising, zero falling edge
// [R14] Status writes ignored, reset keeps flags
// [R15] Selected edge sets capture flag
// [R16] Wrap sets overflow, status+counter clears
// [R17] Timer runs and interrupts in wait
// [R18] Stop freezes counter, resumes unchanged
// [R19] Reset exit from stop presets counter
// [R20] Stop edge arms, flag appears at wake
// [R21] Reset exit discards armed stop capture
// [R22] Reset presets counter to start value
// [R23] Overflow interrupt needs overflow enable
// [R24] Interrupt on enabled capture or overflow
`timescale 1ns/1ps
module tic_top (
	input wire logic clk_i,
	input wire logic rst_i,
	// Classic Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Capture input pin paths
	input wire logic capture_input_pin_i,
	input wire logic capture_comparator_i,
	// Port B bit zero data from the port logic
	input wire logic port_b_bit_zero_data_i,
	// Stop mode level from power control
	input wire logic stop_i,
	output logic comparator_enable_o,
	output logic port_b_force_input_o,
	output logic port_b_bit_zero_read_o,
	output logic timer_irq_o
);
	// All state of the capture core
	typedef struct packed {
		logic ack; // Bus acknowledge
		logic [7:0] dat; // Read data byte
		logic irq; // Interrupt request
		logic [15:0] cnt; // Free-running counter
		logic [1:0] presc; // Divide by four prescaler
		logic [15:0] cap; // Capture value
		logic cap_flag; // Capture flag
		logic ovf_flag; // Overflow flag
		logic cap_rd_arm; // Status read seen with capture flag set
		logic ovf_rd_arm; // Status read seen with overflow flag set
		logic inhibit; // High byte read blocks transfers
		logic armed; // Edge seen during stop
		logic [15:0] arm_val; // Value latched by that edge
		logic cap_ie; // Capture interrupt enable
		logic ovf_ie; // Overflow interrupt enable
		logic edge_pol; // Edge polarity
		logic cmp_sel; // Comparator select
		logic force_in; // Port bit forced to input
		logic pb_rd; // Port bit read value
		logic stop_prev; // Stop level one cycle earlier
	} tic_main_s;

	tic_main_s st_q = '0;
	tic_main_s st_d;

	tic_cond_if cif ();

	// Bus decode helpers
	logic req; // New request waiting for an answer
	logic rd_hit; // Read access in this cycle
	logic wr_hit; // Write access with low byte lane
	logic [7:0] rd_byte; // Selected read data
	logic wake; // Stop released without reset

	assign cif.cmp_sel = st_q.cmp_sel;
	assign cif.edge_pol = st_q.edge_pol;

	// Input synchroniser, path select and edge detection
	tic_cond u_cond (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.schmitt_i(capture_input_pin_i),
		.comparator_i(capture_comparator_i),
		.cif(cif)
	);

	// Access decode: one answer per request, ack falls the cycle after
	always_comb begin
		req = wb_cyc_i && wb_stb_i && !st_q.ack;
		rd_hit = req && !wb_we_i;
		wr_hit = req && wb_we_i && wb_sel_i[0];
		wake = st_q.stop_prev && !stop_i && !rst_i;
	end

	// Read data mux; unmapped addresses read as zero
	always_comb begin
		rd_byte = tic_pkg::BYTE_ZERO;
		case (wb_adr_i)
			tic_pkg::ADR_CTRL: begin
				rd_byte[tic_pkg::CTL_CAP_IE] = st_q.cap_ie;
				rd_byte[tic_pkg::CTL_OVF_IE] = st_q.ovf_ie;
				rd_byte[tic_pkg::CTL_EDGE_POL] = st_q.edge_pol;
			end
			tic_pkg::ADR_STAT: begin
				rd_byte[tic_pkg::STA_CAP_FLAG] = st_q.cap_flag;
				rd_byte[tic_pkg::STA_OVF_FLAG] = st_q.ovf_flag;
			end
			tic_pkg::ADR_CAP_HI: rd_byte = st_q.cap[15:8];
			tic_pkg::ADR_CAP_LO: rd_byte = st_q.cap[7:0];
			tic_pkg::ADR_CNT_HI: rd_byte = st_q.cnt[15:8];
			tic_pkg::ADR_CNT_LO: rd_byte = st_q.cnt[7:0];
			tic_pkg::ADR_CFG: rd_byte[tic_pkg::CFG_CMP_SEL] = st_q.cmp_sel;
			default: rd_byte = tic_pkg::BYTE_ZERO;
		endcase
	end

	// Next state of the whole core
	always_comb begin
		st_d = st_q;
		st_d.ack = req;
		st_d.stop_prev = stop_i;
		if (rd_hit) begin
			st_d.dat = rd_byte;
		end

		// Register writes; status and capture bytes ignore writes
		if (wr_hit) begin
			case (wb_adr_i)
				tic_pkg::ADR_CTRL: begin
					st_d.cap_ie = wb_dat_i[tic_pkg::CTL_CAP_IE]; // see [R11]
					st_d.ovf_ie = wb_dat_i[tic_pkg::CTL_OVF_IE]; // see [R12]
					st_d.edge_pol = wb_dat_i[tic_pkg::CTL_EDGE_POL]; // see [R13]
				end
				tic_pkg::ADR_CFG: st_d.cmp_sel = wb_dat_i[tic_pkg::CFG_CMP_SEL]; // see [R01]
				default: st_d.cmp_sel = st_q.cmp_sel; // see [R14] [R05]
			endcase
		end

		// Read side effects on the flag clearing sequences
		if (rd_hit) begin
			case (wb_adr_i)
				tic_pkg::ADR_STAT: begin
					st_d.cap_rd_arm = st_q.cap_flag; // see [R09]
					st_d.ovf_rd_arm = st_q.ovf_flag; // see [R16]
				end
				tic_pkg::ADR_CAP_HI: st_d.inhibit = 1'b1; // see [R08]
				tic_pkg::ADR_CAP_LO: begin
					st_d.inhibit = 1'b0; // see [R08]
					if (st_q.cap_rd_arm) begin
						st_d.cap_flag = 1'b0; // see [R09]
						st_d.cap_rd_arm = 1'b0;
					end
				end
				tic_pkg::ADR_CNT_LO: begin
					if (st_q.ovf_rd_arm) begin
						st_d.ovf_flag = 1'b0; // see [R16]
						st_d.ovf_rd_arm = 1'b0;
					end
				end
				default: st_d.inhibit = st_q.inhibit;
			endcase
		end

		// Counter runs through the prescaler except in stop; wait is no stop
		if (!stop_i) begin
			st_d.presc = st_q.presc + tic_pkg::PRESC_STEP; // see [R07] [R17]
			if (st_q.presc == tic_pkg::PRESC_LAST) begin
				st_d.cnt = st_q.cnt + tic_pkg::CNT_STEP; // see [R07]
				if (st_q.cnt == tic_pkg::CNT_MAX) begin
					st_d.ovf_flag = 1'b1; // see [R16]
				end
			end
		end
		// Frozen counter keeps its value in stop, see [R18]

		// Edge during stop only arms; first edge wins
		if (stop_i && cif.edge_hit && !st_q.armed) begin
			st_d.armed = 1'b1; // see [R20]
			st_d.arm_val = st_q.cnt + tic_pkg::CNT_STEP; // see [R06]
		end

		// Leaving stop by interrupt delivers the armed capture
		if (wake && st_q.armed) begin
			st_d.armed = 1'b0;
			st_d.cap_flag = 1'b1; // see [R20]
			if (!st_q.inhibit) begin
				st_d.cap = st_q.arm_val; // see [R20]
			end
		end

		// Running edge sets the flag and transfers unless inhibited
		if (!stop_i && cif.edge_hit) begin
			st_d.cap_flag = 1'b1; // see [R15]
			if (!st_q.inhibit) begin
				st_d.cap = st_q.cnt + tic_pkg::CNT_STEP; // see [R04] [R06]
			end
		end

		// Interrupt request from enabled flags
		st_d.irq = (st_q.cap_flag && st_q.cap_ie) || (st_q.ovf_flag && st_q.ovf_ie); // see [R24] [R11] [R23]

		// Comparator enable forces the shared port bit to input
		st_d.force_in = st_q.cmp_sel; // see [R02]
		if (st_q.force_in) begin
			st_d.pb_rd = cif.level; // see [R02]
		end else begin
			st_d.pb_rd = port_b_bit_zero_data_i;
		end

		// Device reset; flags, capture bytes and polarity survive
		if (rst_i) begin
			st_d.ack = 1'b0;
			st_d.dat = tic_pkg::BYTE_ZERO;
			st_d.cnt = tic_pkg::CNT_RESET; // see [R22] [R19]
			st_d.presc = '0;
			st_d.cap_ie = 1'b0; // see [R10]
			st_d.ovf_ie = 1'b0; // see [R10]
			st_d.cmp_sel = 1'b0;
			st_d.force_in = 1'b0;
			st_d.inhibit = 1'b0;
			st_d.armed = 1'b0; // see [R21]
			st_d.cap_rd_arm = 1'b0;
			st_d.ovf_rd_arm = 1'b0;
			st_d.stop_prev = 1'b0;
			st_d.cap_flag = st_q.cap_flag; // see [R14]
			st_d.ovf_flag = st_q.ovf_flag; // see [R14]
			st_d.cap = st_q.cap; // see [R05] [R21]
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		st_q <= st_d;
	end

	// Outputs straight from flops
	assign wb_dat_o = {24'h000000, st_q.dat};
	assign wb_ack_o = st_q.ack;
	assign comparator_enable_o = st_q.cmp_sel;
	assign port_b_force_input_o = st_q.force_in;
	assign port_b_bit_zero_read_o = st_q.pb_rd;
	assign timer_irq_o = st_q.irq;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	a_cnt_prescale_step: assert property ( // see [R07]
		!stop_i && st_q.presc == tic_pkg::PRESC_LAST |=>
		st_q.cnt == $past(st_q.cnt) + tic_pkg::CNT_STEP)
		else $error("Counter did not step at prescaler end");
	a_cnt_reset_preset: assert property (disable iff (1'b0) // see [R22]
		rst_i |=> st_q.cnt == tic_pkg::CNT_RESET && st_q.presc == '0)
		else $error("Counter not preset by reset");
	a_stop_cnt_frozen: assert property ( // see [R18]
		stop_i ##1 stop_i |-> st_q.cnt == $past(st_q.cnt))
		else $error("Counter moved in stop");
	a_cap_load_value: assert property ( // see [R06]
		!stop_i && cif.edge_hit && !st_q.inhibit |=>
		st_q.cap == $past(st_q.cnt) + tic_pkg::CNT_STEP)
		else $error("Capture value wrong");
	a_cap_inhibit_hold: assert property ( // see [R08]
		st_q.inhibit && !wake |=> st_q.cap == $past(st_q.cap))
		else $error("Capture changed while inhibited");
	a_cap_flag_set: assert property ( // see [R15]
		!stop_i && cif.edge_hit |=> st_q.cap_flag)
		else $error("Capture flag not set");
	a_stop_no_flag: assert property ( // see [R20]
		stop_i && !st_q.stop_prev && !st_q.cap_flag ##1 stop_i |-> !st_q.cap_flag)
		else $error("Flag set during stop");
	a_ovf_wrap_flag: assert property ( // see [R16]
		!stop_i && st_q.presc == tic_pkg::PRESC_LAST && st_q.cnt == tic_pkg::CNT_MAX |=>
		st_q.ovf_flag && st_q.cnt == '0)
		else $error("Overflow flag not set on wrap");
	a_stat_wr_keep: assert property ( // see [R14]
		wr_hit && wb_adr_i == tic_pkg::ADR_STAT |=>
		(st_q.cap_flag || !$past(st_q.cap_flag)) && (st_q.ovf_flag || !$past(st_q.ovf_flag)))
		else $error("Status write cleared a flag");
	a_irq_cap_en: assert property ( // see [R11]
		st_q.cap_flag && st_q.cap_ie |=> timer_irq_o)
		else $error("Enabled capture gave no interrupt");
	a_irq_ovf_gate: assert property ( // see [R23]
		!st_q.ovf_ie && !(st_q.cap_flag && st_q.cap_ie) |=> !timer_irq_o)
		else $error("Interrupt without enabled flag");
	a_ctl_reset_pol: assert property (disable iff (1'b0) // see [R10]
		rst_i |=> !st_q.cap_ie && !st_q.ovf_ie && st_q.edge_pol == $past(st_q.edge_pol))
		else $error("Control reset wrong");
	a_force_input: assert property ( // see [R02]
		st_q.cmp_sel ##1 st_q.cmp_sel |-> port_b_force_input_o)
		else $error("Port bit not forced to input");
endmodule : tic_top

// File: shared/tic_pkg.sv
// Constants for the timer input capture and flag block.
// Assumes a 32-bit classic Wishbone slave with byte data in bits 7:0.
package tic_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_CTRL = 8'h12; // Timer control register
	localparam logic [7:0] IDX_STAT = 8'h13; // Timer status register
	localparam logic [7:0] IDX_CAP_HI = 8'h14; // Capture high byte
	localparam logic [7:0] IDX_CAP_LO = 8'h15; // Capture low byte
	localparam logic [7:0] IDX_CNT_HI = 8'h18; // Counter high byte
	localparam logic [7:0] IDX_CNT_LO = 8'h19; // Counter low byte
	localparam logic [7:0] IDX_CFG = 8'h1a; // Capture input configuration
	// Byte addresses
	localparam logic [7:0] ADR_CTRL = {IDX_CTRL[5:0], 2'h0};
	localparam logic [7:0] ADR_STAT = {IDX_STAT[5:0], 2'h0};
	localparam logic [7:0] ADR_CAP_HI = {IDX_CAP_HI[5:0], 2'h0};
	localparam logic [7:0] ADR_CAP_LO = {IDX_CAP_LO[5:0], 2'h0};
	localparam logic [7:0] ADR_CNT_HI = {IDX_CNT_HI[5:0], 2'h0};
	localparam logic [7:0] ADR_CNT_LO = {IDX_CNT_LO[5:0], 2'h0};
	localparam logic [7:0] ADR_CFG = {IDX_CFG[5:0], 2'h0};
	// Control register bit positions
	localparam int CTL_CAP_IE = 7; // Capture interrupt enable
	localparam int CTL_OVF_IE = 5; // Overflow interrupt enable
	localparam int CTL_EDGE_POL = 1; // Capture edge polarity
	// Status register bit positions
	localparam int STA_CAP_FLAG = 7; // Capture flag
	localparam int STA_OVF_FLAG = 5; // Overflow flag
	// Configuration register bit positions
	localparam int CFG_CMP_SEL = 0; // Comparator select
	// Counter constants
	localparam logic [15:0] CNT_RESET = 16'hfffc; // Preset after device reset
	localparam logic [15:0] CNT_MAX = 16'hffff; // Last count before wrap
	localparam logic [15:0] CNT_STEP = 16'h0001; // One count
	localparam logic [1:0] PRESC_LAST = 2'h3; // Divide by four prescaler end
	localparam logic [1:0] PRESC_STEP = 2'h1; // Prescaler step
	localparam logic [7:0] BYTE_ZERO = 8'h00; // Unmapped or reserved read
endpackage : tic_pkg

// File: shared/tic_cond_if.sv
// Carrier between the capture core and the input conditioner.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface tic_cond_if;
	logic cmp_sel; // Comparator path selected
	logic edge_pol; // High selects rising edge
	logic level; // Conditioned, synchronised input level
	logic edge_hit; // One-cycle pulse on a selected edge
	modport core (output cmp_sel, output edge_pol, input level, input edge_hit);
	modport cond (input cmp_sel, input edge_pol, output level, output edge_hit);
endinterface : tic_cond_if

// File: rtl/tic_cond.sv
// Capture input conditioner: synchronises both input paths, selects one,
// and detects the selected edge. Assumes pins are asynchronous to clk_i.
`timescale 1ns/1ps
module tic_cond (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic schmitt_i,
	input wire logic comparator_i,
	tic_cond_if.cond cif
);
	// All state of the conditioner
	typedef struct packed {
		logic s1_sch; // First synchroniser stage, trigger path
		logic s2_sch; // Second synchroniser stage, trigger path
		logic s1_cmp; // First synchroniser stage, comparator path
		logic s2_cmp; // Second synchroniser stage, comparator path
		logic lvl; // Selected level
		logic prev; // Level one cycle earlier
		logic prime1; // Level history filling after reset
		logic prime2; // History valid, edges may be reported
		logic hit; // Registered edge pulse
	} tic_cond_s;

	tic_cond_s st_q = '0;
	tic_cond_s st_d;

	// Next state of the conditioner
	always_comb begin
		st_d = st_q;
		st_d.s1_sch = schmitt_i;
		st_d.s2_sch = st_q.s1_sch;
		st_d.s1_cmp = comparator_i;
		st_d.s2_cmp = st_q.s1_cmp;
		st_d.lvl = cif.cmp_sel ? st_q.s2_cmp : st_q.s2_sch; // see [R01]
		st_d.prev = st_q.lvl;
		st_d.prime1 = 1'b1;
		st_d.prime2 = st_q.prime1;
		// Rising or falling edge as polarity asks
		if (cif.edge_pol) begin
			st_d.hit = st_q.prime2 && st_q.lvl && !st_q.prev; // see [R13]
		end else begin
			st_d.hit = st_q.prime2 && !st_q.lvl && st_q.prev; // see [R13]
		end
		// Reset lets the synchronisers run and levels the history, so a pin
		// that rests high through reset shows no false edge after release
		if (rst_i) begin
			st_d.prev = st_d.lvl;
			st_d.prime1 = 1'b0;
			st_d.prime2 = 1'b0;
			st_d.hit = 1'b0;
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		st_q <= st_d;
	end

	assign cif.level = st_q.lvl;
	assign cif.edge_hit = st_q.hit;

	a_cond_select_path: assert property (@(posedge clk_i) disable iff (rst_i) // see [R01]
		cif.cmp_sel && st_q.s2_cmp |=> st_q.lvl)
		else $error("Comparator path not selected");
	a_edge_rise_hit: assert property (@(posedge clk_i) disable iff (rst_i) // see [R13]
		cif.edge_pol && st_q.prime2 && st_q.lvl && !st_q.prev |=> st_q.hit)
		else $error("Rising edge missed");
endmodule : tic_cond

// File: bench/tic_pin_model.sv
// Far-side model of the capture pin: drives both input paths.
// Assumes the bench moves the level just after a rising clock edge.
`timescale 1ns/1ps
module tic_pin_model (
	input wire logic level_i,
	input wire logic use_cmp_i,
	output logic schmitt_o,
	output logic comparator_o
);
	// Unselected path carries the inverse, so a wrong path choice shows up
	assign schmitt_o = use_cmp_i ? ~level_i : level_i;
	assign comparator_o = use_cmp_i ? level_i : ~level_i;
endmodule : tic_pin_model

// File: bench/tic_top_bench.sv
// Self-checking bench for the timer capture block: bus, edges, stop, reset.
// Assumes tic_pkg, tic_top and tic_pin_model are compiled before it.
`timescale 1ns/1ps
`define CK(n, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
	$display("MISMATCH %s expected %h seen %h", n, e, g); end end
module tic_top_bench;
	localparam logic [7:0] A_CT = tic_pkg::ADR_CTRL; // Control
	localparam logic [7:0] A_ST = tic_pkg::ADR_STAT; // Status
	localparam logic [7:0] A_CH = tic_pkg::ADR_CAP_HI; // Capture high
	localparam logic [7:0] A_CL = tic_pkg::ADR_CAP_LO; // Capture low
	localparam logic [7:0] A_NH = tic_pkg::ADR_CNT_HI; // Counter high
	localparam logic [7:0] A_NL = tic_pkg::ADR_CNT_LO; // Counter low
	localparam logic [7:0] A_CF = tic_pkg::ADR_CFG; // Input config
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic ack;
	logic level = 1'b0; // Pin level asked of the model
	logic use_cmp = 1'b0; // Model drives the comparator path
	logic schm;
	logic cmpo;
	logic pdata = 1'b0; // Port register bit
	logic stop = 1'b0; // Stop mode level
	logic cmp_en;
	logic force_in;
	logic pread;
	logic irq;
	logic [7:0] q, c0, c1, h, l, d; // Read results
	int num_errors = 0;
	int check_count = 0;
	// Clock at 100 MHz
	always #5 clk_i = ~clk_i;
	tic_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .capture_input_pin_i(schm), .capture_comparator_i(cmpo),
		.port_b_bit_zero_data_i(pdata), .stop_i(stop), .comparator_enable_o(cmp_en),
		.port_b_force_input_o(force_in), .port_b_bit_zero_read_o(pread), .timer_irq_o(irq));
	tic_pin_model u_pin (.level_i(level), .use_cmp_i(use_cmp), .schmitt_o(schm),
		.comparator_o(cmpo));
	// Prints the counts and the verdict, then ends the run
	task give_verdict;
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : give_verdict
	task wt(input int n);
		repeat (n) @(posedge clk_i);
	endtask : wt
	// One classic Wishbone cycle; read byte lands in q
	task bus(input logic w, input logic [7:0] a, input logic [7:0] dw);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h000000, dw};
		// Request held until ack is seen high; only the watchdog ends a hang
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : bus
	task do_reset;
		@(posedge clk_i);
		rst_i <= 1'b1;
		wt(5);
		rst_i <= 1'b0;
	endtask : do_reset
	// Status read, then both low bytes: clears armed flags
	task clr;
		bus(1'b0, A_ST, 8'h00);
		bus(1'b0, A_CL, 8'h00);
		bus(1'b0, A_NL, 8'h00);
	endtask : clr
	task t_regs;
		bus(1'b0, A_NH, 8'h00);
		`CK("cnt hi", 8'hff, q)
		bus(1'b1, A_CT, 8'ha2);
		wt(40);
		bus(1'b0, A_ST, 8'h00);
		`CK("ovf flag", 1'b1, q[5])
		`CK("irq ovf", 1'b1, irq)
		bus(1'b1, A_ST, 8'h00);
		bus(1'b0, A_ST, 8'h00);
		`CK("stat write", 1'b1, q[5])
		bus(1'b0, A_NL, 8'h00);
		bus(1'b0, A_ST, 8'h00);
		`CK("ovf clear", 1'b0, q[5])
		`CK("irq idle", 1'b0, irq)
		do_reset();
		bus(1'b0, A_CT, 8'h00);
		`CK("ctrl reset", 8'h02, q)
		wt(40);
		`CK("irq masked", 1'b0, irq)
		// The flag really stands while the enable is off
		bus(1'b0, A_ST, 8'h00);
		`CK("ovf masked", 1'b1, q[5])
		clr();
		bus(1'b1, 8'hfc, 8'hff);
		bus(1'b0, 8'hfc, 8'h00);
		`CK("unmapped", 8'h00, q)
		bus(1'b0, A_NL, 8'h00);
		c0 = q;
		wt(37);
		bus(1'b0, A_NL, 8'h00);
		`CK("cnt rate", 8'h0a, q - c0)
	endtask : t_regs
	// Every polarity on both input paths, enable on and off
	task t_edges;
		logic p, m;
		for (int i = 0; i < 4; i++) begin
			p = i[0];
			m = i[1];
			use_cmp <= m; // Pin settled before the comparator is chosen
			bus(1'b1, A_CF, {7'h00, m});
			bus(1'b1, A_CT, {m, 5'h00, p, 1'b0});
			level <= p;
			pdata <= ~p;
			wt(10);
			clr();
			level <= ~p;
			wt(10);
			bus(1'b0, A_ST, 8'h00);
			`CK("wrong edge", 1'b0, q[7])
			level <= p;
			wt(10);
			bus(1'b0, A_ST, 8'h00);
			`CK("edge flag", 1'b1, q[7])
			`CK("irq cap", m, irq)
			`CK("cmp enable", m, cmp_en)
			`CK("force input", m, force_in)
			`CK("port read", (m ? p : ~p), pread)
		end
	endtask : t_edges
	// Rising edges with polarity one; captured value window and inhibit
	task t_inhibit;
		clr();
		level <= 1'b0;
		wt(10);
		bus(1'b0, A_NL, 8'h00);
		c0 = q;
		level <= 1'b1;
		wt(10);
		bus(1'b0, A_NL, 8'h00);
		c1 = q;
		bus(1'b0, A_CL, 8'h00);
		h = q;
		d = h - c0 - 8'h01;
		// At least one count passes between the first read and the edge pulse
		`CK("cap window", 1'b1, (d >= 8'h01 && d <= c1 - c0))
		bus(1'b0, A_CH, 8'h00);
		level <= 1'b0;
		wt(10);
		level <= 1'b1;
		wt(10);
		bus(1'b0, A_ST, 8'h00);
		bus(1'b0, A_CL, 8'h00);
		`CK("inhibited", h, q)
		bus(1'b0, A_ST, 8'h00);
		`CK("flag clear", 1'b0, q[7])
		level <= 1'b0;
		wt(10);
		level <= 1'b1;
		wt(10);
		bus(1'b0, A_CL, 8'h00);
		`CK("new capture", 1'b1, (q != h))
	endtask : t_inhibit
	// Edge in stop arms; wake by stop release, then reset keeps data
	task t_stop;
		clr();
		level <= 1'b0;
		stop <= 1'b1;
		wt(2);
		bus(1'b0, A_NH, 8'h00);
		h = q;
		bus(1'b0, A_NL, 8'h00);
		l = q;
		wt(20);
		bus(1'b0, A_NL, 8'h00);
		`CK("frozen", l, q)
		level <= 1'b1;
		wt(10);
		bus(1'b0, A_ST, 8'h00);
		`CK("stop flag", 1'b0, q[7])
		stop <= 1'b0;
		wt(10);
		// Data read before the status, so the flag is still set at reset
		bus(1'b0, A_CH, 8'h00);
		c0 = q;
		bus(1'b0, A_CL, 8'h00);
		c1 = q;
		`CK("stop cap", {h, l} + 16'h0001, {c0, c1})
		bus(1'b0, A_ST, 8'h00);
		`CK("wake flag", 1'b1, q[7])
		do_reset();
		bus(1'b0, A_CL, 8'h00);
		`CK("cap kept", c1, q)
		bus(1'b0, A_ST, 8'h00);
		`CK("flag kept", 1'b1, q[7])
	endtask : t_stop
	// Stop left through reset: armed edge discarded, counter preset
	task t_stop_reset;
		clr();
		level <= 1'b0;
		stop <= 1'b1;
		wt(5);
		level <= 1'b1;
		wt(10);
		rst_i <= 1'b1;
		wt(5);
		rst_i <= 1'b0;
		stop <= 1'b0;
		bus(1'b0, A_NH, 8'h00);
		`CK("preset", 8'hff, q)
		bus(1'b0, A_ST, 8'h00);
		`CK("no flag", 1'b0, q[7])
		bus(1'b0, A_CL, 8'h00);
		`CK("no data", c1, q)
	endtask : t_stop_reset
	// Main sequence
	initial begin
		wt(5);
		rst_i <= 1'b0;
		t_regs();
		t_edges();
		t_inhibit();
		t_stop();
		t_stop_reset();
		give_verdict();
	end
	// Watchdog against a hung handshake
	initial begin
		wt(20000);
		num_errors++;
		give_verdict();
	end
endmodule : tic_top_bench
